// *** pkg/adc_ctrl_defines.vh ***
// constants for the converter control block: offsets, fields, resets, counts
// assumes inclusion by the block's own modules only
//
// Operation
// - codes 0000, 0100, 11xx select external channel
// - codes 0001-0011 select supply scaled 1, 1/2, 1/4
// - codes 0101-0111 select amplifier output, scaled
// - codes 1000-1011 reserved, input tied to ground
// - internal source disconnects external channel
// - select register bit 3 reads zero
// - divide codes give fsys over 1 to 128
// - amplifier register bits 6 and 5 read zero
// - amplifier input: pin at 0, bandgap at 1
// - bandgap wins over amplifier input pin
// - reference: supply 00, pin 01, amplifier 1x
// - internal reference wins over reference pin
// - gain codes give 1, 1.667, 2.5, 3.333
// - start bit written high then low starts
// - busy set at start, cleared at completion
// - completion raises interrupt request toward controller; the block has no interrupt output, it only pulses CONV_DONE for one cycle
// - conversion is 4 sample plus 12 convert clocks
// - format bit picks left or right justification
// - disabled converter leaves result registers unchanged
// - unimplemented channel code leaves input floating
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_MAIN_CONTROL   8'h00
`define OFS_INPUT_CLOCK    8'h04
`define OFS_AMP_REFERENCE  8'h08
`define OFS_RESULT_LOW     8'h0C
`define OFS_RESULT_HIGH    8'h10

// ----------------------------------------------------------------
// main control fields
// ----------------------------------------------------------------
`define MAIN_START_BIT     7
`define MAIN_BUSY_BIT      6
`define MAIN_ENABLE_BIT    5
`define MAIN_FORMAT_BIT    4
`define MAIN_CHAN_MSB      3
`define MAIN_CHAN_LSB      0

// ----------------------------------------------------------------
// input and clock select fields
// ----------------------------------------------------------------
`define SEL_SRC_MSB        7
`define SEL_SRC_LSB        4
`define SEL_DIV_MSB        2
`define SEL_DIV_LSB        0

// ----------------------------------------------------------------
// amplifier and reference fields
// ----------------------------------------------------------------
`define AMP_EN_BIT         7
`define AMP_IN_BIT         4
`define AMP_REF_MSB        3
`define AMP_REF_LSB        2
`define AMP_GAIN_MSB       1
`define AMP_GAIN_LSB       0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_MAIN_CONTROL   8'h00
`define RST_INPUT_CLOCK    8'h00
`define RST_AMP_REFERENCE  8'h00

// ----------------------------------------------------------------
// conversion timing in converter clocks
// ----------------------------------------------------------------
`define SAMPLE_CLOCKS      5'h04
`define CONVERT_CLOCKS     5'h0C
`define TOTAL_CLOCKS       5'h10

`endif

// *** verilog/adc_clk_div.v ***
// converter clock divider: one tick per converter clock period
// assumes run is low between conversions so each one starts aligned
`timescale 1ns/1ps
`default_nettype none

module adc_clk_div #(
  parameter DIV_W = 7
) (
  // clock and control
  input  wire             clk,
  input  wire             reset,
  input  wire             ce,
  // divider setting
  input  wire             run,
  input  wire [2:0]       div_sel,
  // tick out
  output reg              tick
);

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  reg  [DIV_W-1:0] count_reg;
  wire [DIV_W-1:0] last;

  // period of 2**code system clocks; wraps cleanly at code 111
  assign last = ({{(DIV_W-1){1'b0}}, 1'b1} << div_sel) -
                {{(DIV_W-1){1'b0}}, 1'b1};

  always @(posedge clk) begin
    if (reset) begin
      count_reg <= {DIV_W{1'b0}};
      tick      <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        count_reg <= {DIV_W{1'b0}};
        tick      <= 1'b0;
      end else if (count_reg == last) begin
        count_reg <= {DIV_W{1'b0}};
        tick      <= 1'b1;
      end else begin
        count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        tick      <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** verilog/adc_ctrl.v ***
// converter control: ahb-lite registers, source and reference routing,
// conversion sequencer
// assumes the analog macro holds RESULT_IN stable when CONV_DONE pulses
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.vh"

module adc_ctrl #(
  parameter NUM_CHANNELS = 16,
  parameter ADDR_W       = 8
) (
  // clock, reset, enable
  input  wire              REF_CLK,
  input  wire              RESET,
  input  wire              CLK_EN,
  // ahb-lite slave
  input  wire              HSEL,
  input  wire [ADDR_W-1:0] HADDR,
  input  wire [1:0]        HTRANS,
  input  wire              HWRITE,
  input  wire [2:0]        HSIZE,
  input  wire              HREADY,
  input  wire [31:0]       HWDATA,
  output reg  [31:0]       HRDATA,
  output reg               HREADYOUT,
  output reg               HRESP,
  // converter macro
  input  wire [11:0]       RESULT_IN,
  output reg               CONV_POWER,
  output wire              CONV_CLK_TICK,
  output reg               CONV_SAMPLE,
  output reg               CONV_BUSY,
  output reg               CONV_DONE,
  // input routing
  output reg               EXT_CH_CONNECT,
  output reg  [3:0]        EXT_CH_SEL,
  output reg               INT_SRC_CONNECT,
  output reg               INT_SRC_AMP,
  output reg  [1:0]        INT_SRC_SCALE,
  output reg               INPUT_GROUND,
  // reference and amplifier
  output reg               REF_SUPPLY,
  output reg               REF_PIN,
  output reg               REF_AMP,
  output reg               AMP_ENABLE,
  output reg               AMP_IN_PIN,
  output reg               AMP_IN_BANDGAP,
  output reg  [1:0]        AMP_GAIN
);

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  localparam [1:0] IDLE    = 2'b00;
  localparam [1:0] SAMPLE  = 2'b01;
  localparam [1:0] CONVERT = 2'b10;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  localparam [7:0] MAIN_RST = `RST_MAIN_CONTROL;
  reg        start_reg;
  reg        enable_reg;
  reg        format_reg;
  reg  [3:0] chan_reg;
  reg  [3:0] src_reg;
  reg  [2:0] div_reg;
  reg        amp_en_reg;
  reg        amp_in_reg;
  reg  [1:0] vref_reg;
  reg  [1:0] gain_reg;
  reg  [11:0] result_reg;

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  reg              wr_pend_reg;
  reg              rd_pend_reg;
  reg [ADDR_W-1:0] addr_reg;
  wire             accept;

  assign accept = HSEL && HTRANS[1] && HREADY;

  // ----------------------------------------------------------------
  // sequencer signals
  // ----------------------------------------------------------------
  reg  [1:0] state_reg;
  reg  [1:0] state_next;
  reg  [4:0] cnt_reg;
  reg  [4:0] cnt_next;
  reg        start_d_reg;
  reg        armed_reg;
  wire       start_rise;
  wire       start_fall;
  wire       launch;
  wire       tick;
  wire       finish;
  wire       run;

  assign start_rise = start_reg && !start_d_reg;
  assign start_fall = !start_reg && start_d_reg;
  // busy conversions and a disabled converter ignore the sequence
  assign launch = start_fall && armed_reg && enable_reg &&
                  (state_reg == IDLE);
  assign run    = (state_reg != IDLE);
  assign finish = (state_reg == CONVERT) && tick &&
                  (cnt_reg == `TOTAL_CLOCKS - 5'h01);

  adc_clk_div #(
    .DIV_W   (7)
  ) u_div (
    .clk     (REF_CLK),
    .reset   (RESET),
    .ce      (CLK_EN),
    .run     (run),
    .div_sel (div_reg),
    .tick    (tick)
  );

  assign CONV_CLK_TICK = tick;

  // ----------------------------------------------------------------
  // register writes, data phase
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RESET) begin
      start_reg  <= MAIN_RST[`MAIN_START_BIT];
      enable_reg <= MAIN_RST[`MAIN_ENABLE_BIT];
      format_reg <= MAIN_RST[`MAIN_FORMAT_BIT];
      chan_reg   <= MAIN_RST[`MAIN_CHAN_MSB:`MAIN_CHAN_LSB];
      src_reg    <= 4'h0;
      div_reg    <= 3'h0;
      amp_en_reg <= 1'b0;
      amp_in_reg <= 1'b0;
      vref_reg   <= 2'h0;
      gain_reg   <= 2'h0;
    end else if (CLK_EN && wr_pend_reg) begin
      case (addr_reg)
        `OFS_MAIN_CONTROL: begin
          start_reg  <= HWDATA[`MAIN_START_BIT];
          enable_reg <= HWDATA[`MAIN_ENABLE_BIT];
          format_reg <= HWDATA[`MAIN_FORMAT_BIT];
          chan_reg   <= HWDATA[`MAIN_CHAN_MSB:`MAIN_CHAN_LSB];
        end
        `OFS_INPUT_CLOCK: begin
          src_reg <= HWDATA[`SEL_SRC_MSB:`SEL_SRC_LSB];
          div_reg <= HWDATA[`SEL_DIV_MSB:`SEL_DIV_LSB];
        end
        `OFS_AMP_REFERENCE: begin
          amp_en_reg <= HWDATA[`AMP_EN_BIT];
          amp_in_reg <= HWDATA[`AMP_IN_BIT];
          vref_reg   <= HWDATA[`AMP_REF_MSB:`AMP_REF_LSB];
          gain_reg   <= HWDATA[`AMP_GAIN_MSB:`AMP_GAIN_LSB];
        end
        default: begin
          start_reg <= start_reg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bus handshake; reads take one wait state so a write just before
  // is already visible, at the cost of a slower read
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RESET) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= {ADDR_W{1'b0}};
      HREADYOUT   <= 1'b1;
      HRESP       <= 1'b0;
      HRDATA      <= 32'h0000_0000;
    end else if (CLK_EN) begin
      HRESP       <= 1'b0;
      wr_pend_reg <= accept && HWRITE;
      rd_pend_reg <= accept && !HWRITE;
      if (accept) begin
        addr_reg <= HADDR;
      end
      if (accept && !HWRITE) begin
        HREADYOUT <= 1'b0;
      end else begin
        HREADYOUT <= 1'b1;
      end
      if (rd_pend_reg) begin
        case (addr_reg)
          `OFS_MAIN_CONTROL:
            HRDATA <= {24'h00_0000, start_reg, CONV_BUSY, enable_reg,
                       format_reg, chan_reg};
          `OFS_INPUT_CLOCK:
            HRDATA <= {24'h00_0000, src_reg, 1'b0, div_reg};
          `OFS_AMP_REFERENCE:
            HRDATA <= {24'h00_0000, amp_en_reg, 2'b00, amp_in_reg,
                       vref_reg, gain_reg};
          `OFS_RESULT_LOW:
            HRDATA <= format_reg ?
                      {24'h00_0000, result_reg[7:0]} :
                      {24'h00_0000, result_reg[3:0], 4'h0};
          `OFS_RESULT_HIGH:
            HRDATA <= format_reg ?
                      {28'h000_0000, result_reg[11:8]} :
                      {24'h00_0000, result_reg[11:4]};
          default:
            HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // start detection
  // ----------------------------------------------------------------
  always @(posedge REF_CLK) begin
    if (RESET) begin
      start_d_reg <= 1'b0;
      armed_reg   <= 1'b0;
    end else if (CLK_EN) begin
      start_d_reg <= start_reg;
      if (start_rise) begin
        armed_reg <= 1'b1;
      end else if (start_fall) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      IDLE: begin
        cnt_next = 5'h00;
        if (launch) begin
          state_next = SAMPLE;
        end
      end
      SAMPLE: begin
        if (!enable_reg) begin
          state_next = IDLE;
        end else if (tick) begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == `SAMPLE_CLOCKS - 5'h01) begin
            state_next = CONVERT;
          end
        end
      end
      CONVERT: begin
        if (!enable_reg || finish) begin
          state_next = IDLE;
        end else if (tick) begin
          cnt_next = cnt_reg + 5'h01;
        end
      end
      default: begin
        state_next = IDLE;
        cnt_next   = 5'h00;
      end
    endcase
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      state_reg  <= IDLE;
      cnt_reg    <= 5'h00;
      result_reg <= 12'h000;
      CONV_BUSY  <= 1'b0;
      CONV_DONE  <= 1'b0;
      CONV_SAMPLE <= 1'b0;
    end else if (CLK_EN) begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      CONV_SAMPLE <= (state_next == SAMPLE);
      // a disabled converter aborts and keeps the old result
      if (finish && enable_reg) begin
        result_reg <= RESULT_IN;
      end
      CONV_DONE <= finish && enable_reg;
      if (launch) begin
        CONV_BUSY <= 1'b1;
      end else if (state_next == IDLE) begin
        CONV_BUSY <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // analog routing
  // ----------------------------------------------------------------
  reg ext_sel;
  reg int_sel;

  always @* begin
    ext_sel = (src_reg == 4'h0) || (src_reg == 4'h4) ||
              (src_reg[3:2] == 2'b11);
    int_sel = (src_reg[3] == 1'b0) && (src_reg[1:0] != 2'b00);
  end

  always @(posedge REF_CLK) begin
    if (RESET) begin
      CONV_POWER      <= 1'b0;
      EXT_CH_CONNECT  <= 1'b0;
      EXT_CH_SEL      <= 4'h0;
      INT_SRC_CONNECT <= 1'b0;
      INT_SRC_AMP     <= 1'b0;
      INT_SRC_SCALE   <= 2'h0;
      INPUT_GROUND    <= 1'b0;
      REF_SUPPLY      <= 1'b1;
      REF_PIN         <= 1'b0;
      REF_AMP         <= 1'b0;
      AMP_ENABLE      <= 1'b0;
      AMP_IN_PIN      <= 1'b1;
      AMP_IN_BANDGAP  <= 1'b0;
      AMP_GAIN        <= 2'h0;
    end else if (CLK_EN) begin
      CONV_POWER <= enable_reg;
      // external mux only when chosen and the channel exists
      EXT_CH_CONNECT <= ext_sel && !int_sel &&
                        ({28'h000_0000, chan_reg} < NUM_CHANNELS);
      EXT_CH_SEL      <= chan_reg;
      INT_SRC_CONNECT <= int_sel;
      INT_SRC_AMP     <= src_reg[2];
      INT_SRC_SCALE   <= src_reg[1:0] - 2'h1;
      INPUT_GROUND    <= (src_reg[3:2] == 2'b10);
      // one-hot: the pin only when neither internal source is chosen
      REF_SUPPLY <= (vref_reg == 2'b00);
      REF_PIN    <= (vref_reg == 2'b01);
      REF_AMP    <= vref_reg[1];
      AMP_ENABLE     <= amp_en_reg;
      AMP_IN_PIN     <= !amp_in_reg;
      AMP_IN_BANDGAP <= amp_in_reg;
      AMP_GAIN       <= gain_reg;
    end
  end

endmodule

`default_nettype wire

// *** test/adc_macro_model.sv ***
// converter macro model: hands a raw result to the block while busy
// assumes CONV_BUSY frames each conversion
`timescale 1ns/1ps
`default_nettype none

module adc_macro_model (
  // clock and framing
  input  wire logic        clk,
  input  wire logic        busy,
  input  wire logic [11:0] value,
  // raw result toward the block
  output var  logic [11:0] result
);
  initial result = 12'ha5a;
  // toggles outside a conversion, one cycle behind busy, so a latch two cycles late fails but one cycle late passes
  always @(posedge clk) begin
    if (busy) begin
      result <= value;
    end else begin
      result <= ~result;
    end
  end
endmodule

`default_nettype wire

// *** test/adc_ctrl_props.sv ***
// assertions for the converter control block, bound to its top module
// assumes one slave: HREADY is the block's own HREADYOUT
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_props #(
  parameter NUM_CHANNELS = 16
) (
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       RESET,
  // bus
  input wire logic       HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic       HWRITE,
  input wire logic       HREADY,
  input wire logic       HREADYOUT,
  input wire logic       HRESP,
  // converter
  input wire logic       CONV_POWER,
  input wire logic       CONV_CLK_TICK,
  input wire logic       CONV_SAMPLE,
  input wire logic       CONV_BUSY,
  input wire logic       CONV_DONE,
  // routing
  input wire logic       EXT_CH_CONNECT,
  input wire logic [3:0] EXT_CH_SEL,
  input wire logic       INT_SRC_CONNECT,
  input wire logic       INPUT_GROUND,
  input wire logic       REF_SUPPLY,
  input wire logic       REF_PIN,
  input wire logic       REF_AMP,
  input wire logic       AMP_IN_PIN,
  input wire logic       AMP_IN_BANDGAP
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  // ticks seen while busy; cleared when idle
  logic [5:0] tick_cnt;
  always @(posedge REF_CLK) begin
    if (RESET || !CONV_BUSY) begin
      tick_cnt <= 6'h00;
    end else if (CONV_CLK_TICK) begin
      tick_cnt <= tick_cnt + 6'h01;
    end
  end

  sequence s_rd_taken;
    HSEL && HTRANS[1] && HREADY && !HWRITE;
  endsequence
  sequence s_rd_answer;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  AST_READ_WAIT: assert property (s_rd_taken |=> s_rd_answer)
    else $error("read not answered after one wait");
  AST_OKAY: assert property (HRESP == 1'b0)
    else $error("error response seen");
  AST_EXT_OFF: assert property (
    INT_SRC_CONNECT |-> !EXT_CH_CONNECT && !INPUT_GROUND)
    else $error("external channel left on");
  AST_GROUND: assert property (
    INPUT_GROUND |-> !EXT_CH_CONNECT && !INT_SRC_CONNECT)
    else $error("grounded input also routed");
  AST_FLOAT: assert property (
    EXT_CH_CONNECT |-> EXT_CH_SEL < NUM_CHANNELS)
    else $error("missing channel connected");
  AST_REF_ONE: assert property (
    $onehot({REF_SUPPLY, REF_PIN, REF_AMP}))
    else $error("reference not one-hot");
  AST_AMP_IN: assert property (AMP_IN_PIN != AMP_IN_BANDGAP)
    else $error("amplifier input not exclusive");
  AST_DONE_END: assert property (
    CONV_DONE |-> !CONV_BUSY && $past(CONV_BUSY))
    else $error("done without busy ending");
  AST_DONE_PULSE: assert property (CONV_DONE |=> !CONV_DONE)
    else $error("done longer than one cycle");
  AST_OFF_IDLE: assert property ((!CONV_POWER) [*3] |-> !CONV_BUSY)
    else $error("busy while converter off");
  AST_TICKS: assert property (
    CONV_DONE |-> tick_cnt >= 6'h0e && tick_cnt <= 6'h10)
    else $error("conversion tick count wrong");
  AST_SAMPLE_BUSY: assert property (CONV_SAMPLE |-> CONV_BUSY)
    else $error("sampling outside a conversion");
endmodule

bind adc_ctrl adc_ctrl_props #(.NUM_CHANNELS(NUM_CHANNELS)) u_props (
  .REF_CLK(REF_CLK), .RESET(RESET), .HSEL(HSEL), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .CONV_POWER(CONV_POWER), .CONV_CLK_TICK(CONV_CLK_TICK),
  .CONV_SAMPLE(CONV_SAMPLE), .CONV_BUSY(CONV_BUSY), .CONV_DONE(CONV_DONE),
  .EXT_CH_CONNECT(EXT_CH_CONNECT), .EXT_CH_SEL(EXT_CH_SEL),
  .INT_SRC_CONNECT(INT_SRC_CONNECT), .INPUT_GROUND(INPUT_GROUND),
  .REF_SUPPLY(REF_SUPPLY), .REF_PIN(REF_PIN), .REF_AMP(REF_AMP),
  .AMP_IN_PIN(AMP_IN_PIN), .AMP_IN_BANDGAP(AMP_IN_BANDGAP));

`default_nettype wire

// *** test/tb_top.sv ***
// bench for the converter control block: bus tasks and scenarios
// assumes one ahb-lite slave and the macro model on RESULT_IN
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk;
  logic        rst;
  logic        ce;
  logic        sel;
  logic        wr_en;
  logic [7:0]  addr;
  logic [1:0]  trans;
  logic [31:0] wdata;
  logic [31:0] q;
  logic [11:0] value;
  wire  [31:0] rdata;
  wire  [11:0] res;
  wire  [1:0]  scale, gain;
  wire  [3:0]  ch;
  wire         rdy, resp, pwr, tick, smp, busy, done, ext, int_c, int_a;
  wire         gnd, r_sup, r_pin, r_amp, a_en, a_pin, a_bg;
  int          failures = 0;
  int          compares = 0;
  int          cyc = 0;
  int          done_cyc = 0;
  int          done_cnt = 0;
  int          smp_cnt = 0;

  // channel count below 16 so missing channels can be probed
  adc_ctrl #(.NUM_CHANNELS(12)) u_dut (
    .REF_CLK(clk), .RESET(rst), .CLK_EN(ce), .HSEL(sel), .HADDR(addr),
    .HTRANS(trans), .HWRITE(wr_en), .HSIZE(3'h2), .HREADY(rdy),
    .HWDATA(wdata), .HRDATA(rdata), .HREADYOUT(rdy), .HRESP(resp),
    .RESULT_IN(res), .CONV_POWER(pwr), .CONV_CLK_TICK(tick),
    .CONV_SAMPLE(smp), .CONV_BUSY(busy), .CONV_DONE(done),
    .EXT_CH_CONNECT(ext), .EXT_CH_SEL(ch), .INT_SRC_CONNECT(int_c),
    .INT_SRC_AMP(int_a), .INT_SRC_SCALE(scale), .INPUT_GROUND(gnd),
    .REF_SUPPLY(r_sup), .REF_PIN(r_pin), .REF_AMP(r_amp),
    .AMP_ENABLE(a_en), .AMP_IN_PIN(a_pin), .AMP_IN_BANDGAP(a_bg),
    .AMP_GAIN(gain));

  adc_macro_model u_model (
    .clk(clk), .busy(busy), .value(value), .result(res));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (smp === 1'b1) begin
      smp_cnt <= smp_cnt + 1;
    end
    if (done === 1'b1) begin
      done_cyc <= cyc;
      done_cnt <= done_cnt + 1;
    end
  end

  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    addr <= a;
    trans <= 2'b10;
    wr_en <= w;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    sel <= 1'b0;
    trans <= 2'b00;
    wdata <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = rdata;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    bus(1'b0, 8'h00, 32'h0);
    chk("main reset", 32'h0, q);
    bus(1'b1, 8'h04, 32'h0000_00ff);
    bus(1'b0, 8'h04, 32'h0);
    chk("sel bit3", 32'h0000_00f7, q);
    bus(1'b1, 8'h08, 32'h0000_00ff);
    bus(1'b0, 8'h08, 32'h0);
    chk("amp bits", 32'h0000_009f, q);
    bus(1'b1, 8'h14, 32'h0000_00ff);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test regs done");
  endtask

  task t_route;
    logic [3:0] s;
    for (int i = 0; i < 16; i++) begin
      s = i[3:0];
      bus(1'b1, 8'h04, {24'h0, s, 4'h0});
      repeat (2) @(posedge clk);
      chk("ext", s == 0 || s == 4 || s > 11, ext);
      chk("int", s[1:0] != 0 && !s[3], int_c);
      chk("gnd", s[3:2] == 2'b10, gnd);
      if (s[1:0] != 0 && !s[3])
        chk("src", {s[2], s[1:0] - 2'h1}, {int_a, scale});
    end
    for (int c = 11; c < 13; c++) begin
      bus(1'b1, 8'h00, c);
      repeat (2) @(posedge clk);
      chk("chan", c < 12, ext);
      chk("chan sel", c, ch);
    end
    $display("test route done");
  endtask

  task t_amp;
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      v = i[4:0];
      bus(1'b1, 8'h08, {24'h0, 3'b100, v});
      repeat (2) @(posedge clk);
      chk("ref", v[3] ? 3'b001 : (v[2] ? 3'b010 : 3'b100),
          {r_sup, r_pin, r_amp});
      chk("amp in", {!v[4], v[4]}, {a_pin, a_bg});
      chk("gain", {1'b1, v[1:0]}, {a_en, gain});
    end
    bus(1'b1, 8'h08, 32'h0);
    $display("test amp done");
  endtask

  task t_conv(input logic [2:0] d, input logic f, input logic [11:0] v);
    int t0;
    int n;
    int dc;
    int sc;
    value <= v;
    dc = done_cnt;
    sc = smp_cnt;
    bus(1'b1, 8'h04, {29'h0, d});
    bus(1'b1, 8'h00, {26'h0, 1'b1, f, 4'h0});
    repeat (8) @(posedge clk);
    chk("power on", 1'b1, pwr);
    bus(1'b1, 8'h00, {24'h0, 2'b10, 1'b1, f, 4'h0});
    bus(1'b1, 8'h00, {26'h0, 1'b1, f, 4'h0});
    t0 = cyc;
    repeat (3) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0);
    chk("busy set", 1'b1, q[6]);
    n = 0;
    while (q[6] === 1'b1 && n < 1000) begin
      bus(1'b0, 8'h00, 32'h0);
      n++;
    end
    chk("busy clear", 1'b0, q[6]);
    chk("done", dc + 1, done_cnt);
    chk("time", 1'b1, done_cyc - t0 >= (16 << d)
        && done_cyc - t0 <= (16 << d) + 6);
    chk("sample", 1'b1, smp_cnt - sc >= (4 << d)
        && smp_cnt - sc <= (4 << d) + 2);
    bus(1'b0, 8'h10, 32'h0);
    chk("high", f ? {4'h0, v[11:8]} : v[11:4], q);
    bus(1'b0, 8'h0c, 32'h0);
    chk("low", f ? v[7:0] : {v[3:0], 4'h0}, q);
    bus(1'b1, 8'h00, {26'h0, 1'b1, !f, 4'h0});
    bus(1'b0, 8'h10, 32'h0);
    chk("reformat", f ? v[11:4] : {4'h0, v[11:8]}, q);
    $display("test conv div %0d done", d);
  endtask

  task t_off;
    int dc;
    dc = done_cnt;
    value = 12'h3c3;
    bus(1'b1, 8'h00, 32'h0000_0080);
    bus(1'b1, 8'h00, 32'h0);
    repeat (40) @(posedge clk);
    chk("no start", dc, done_cnt);
    chk("idle", 1'b0, busy);
    bus(1'b1, 8'h04, 32'h0000_0004);
    bus(1'b1, 8'h00, 32'h0000_0020);
    bus(1'b1, 8'h00, 32'h0000_00a0);
    bus(1'b1, 8'h00, 32'h0000_0020);
    repeat (40) @(posedge clk);
    bus(1'b1, 8'h00, 32'h0);
    repeat (300) @(posedge clk);
    chk("power off", 1'b0, pwr);
    chk("aborted", dc, done_cnt);
    chk("abort idle", 1'b0, busy);
    bus(1'b0, 8'h10, 32'h0);
    chk("kept", 32'h0000_000f, q);
    $display("test off done");
  endtask

  // a write made while the enable is low must not land
  task t_freeze;
    ce <= 1'b0;
    bus(1'b1, 8'h04, 32'h0000_0020);
    ce <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    chk("frozen", 32'h0000_0004, q);
    $display("test freeze done");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    sel = 1'b0;
    addr = 8'h00;
    trans = 2'b00;
    wr_en = 1'b0;
    wdata = 32'h0;
    value = 12'h000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_route;
    t_amp;
    t_conv(3'h0, 1'b0, 12'habc);
    t_conv(3'h2, 1'b1, 12'h5a3);
    t_conv(3'h7, 1'b0, 12'h0f1);
    t_off;
    t_freeze;
    summarize;
  end

  // no run should need more than a few thousand cycles
  initial begin
    #300000;
    failures++;
    summarize;
  end
endmodule

`default_nettype wire
